// [design/hmv_device.sv]
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`default_nettype none
module hmv_device
    import hmv_pkg::*;
#(
    parameter int DW_DELAY = hmv_pkg::DIRECT_WRITE_DELAY_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    hmv_port_if.dev port,
    input wire logic core_wr,
    input wire logic [3:0] core_addr,
    input wire logic [31:0] core_wdata,
    input wire logic core_rti,
    output logic [31:0] core_rdata,
    output logic irq_nop,
    output logic irq_enter,
    output logic [23:0] irq_target,
    output logic [7:0] irq_data,
    output logic status_push,
    output logic status_pop,
    output logic in_service,
    output logic mem_we,
    output logic [3:0] mem_addr,
    output logic [31:0] mem_wdata
);
    import hmv_pkg::*;

    // Counter is four bits wide and must expire at least once
    if (DW_DELAY < 1 || DW_DELAY > DIRECT_WRITE_MAX_DELAY_CYC) begin : g_bad_delay
        $error("DW_DELAY out of range");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {HMV_IDLE, HMV_LATENCY, HMV_SERVICE} hmv_vstate_t;
    typedef struct packed {
        logic [NUM_MSG-1:0][31:0] msg;
        logic [31:0] vector;
        logic vip;
        hmv_vstate_t vstate;
        logic [3:0] lat;
        logic dwp;
        logic [3:0] dw_cnt;
        logic [3:0] dw_addr;
        logic [31:0] dw_data;
        logic ready;
        logic [31:0] rdata;
        logic [31:0] core_rdata;
        logic irq_nop;
        logic irq_enter;
        logic status_push;
        logic status_pop;
        logic in_service;
        logic mem_we;
        logic [3:0] mem_addr;
        logic [31:0] mem_wdata;
    } hmv_dev_state_t;

    hmv_dev_state_t st, next_st;

    function automatic logic [31:0] reg_read(input hmv_dev_state_t s, input logic [3:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a < 4'(NUM_MSG)) begin
            v = s.msg[a[2:0]];
        end else if (a == VECTOR_ADDR) begin
            v = s.vector;
        end else if (a == STATUS_ADDR) begin
            v[STATUS_VIP_BIT] = s.vip;
            v[STATUS_DWP_BIT] = s.dwp;
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.ready = 1'b0;
        next_st.irq_nop = 1'b0;
        next_st.irq_enter = 1'b0;
        next_st.status_push = 1'b0;
        next_st.status_pop = 1'b0;
        next_st.mem_we = 1'b0;
        next_st.core_rdata = reg_read(st, core_addr);
        // Core side access
        if (core_wr) begin
            if (core_addr < 4'(NUM_MSG)) begin
                next_st.msg[core_addr[2:0]] = core_wdata;
            end else if (core_addr == VECTOR_ADDR) begin
                next_st.vector = core_wdata;
            end
        end
        // Host register access, one-cycle ready; direct writes queue one deep
        if (port.req && !st.ready) begin
            if (port.wr && port.direct) begin
                if (!st.dwp) begin
                    next_st.dwp = 1'b1;
                    next_st.dw_cnt = 4'(DW_DELAY);
                    next_st.dw_addr = port.addr;
                    next_st.dw_data = port.wdata;
                    next_st.ready = 1'b1;
                end
            end else begin
                next_st.ready = 1'b1;
                next_st.rdata = reg_read(st, port.addr);
                if (port.wr && port.addr < 4'(NUM_MSG)) begin
                    next_st.msg[port.addr[2:0]] = port.wdata;
                end else if (port.wr && port.addr == VECTOR_ADDR && st.vstate != HMV_SERVICE) begin
                    next_st.vector = port.wdata;
                    next_st.vip = 1'b1;
                end
            end
        end
        // Direct write completes after its delay, possibly after later register writes
        if (st.dwp) begin
            if (st.dw_cnt <= 4'h1) begin
                next_st.dwp = 1'b0;
                next_st.mem_we = 1'b1;
                next_st.mem_addr = st.dw_addr;
                next_st.mem_wdata = st.dw_data;
            end else begin
                next_st.dw_cnt = st.dw_cnt - 4'h1;
            end
        end
        // Vector interrupt sequencing
        unique case (st.vstate)
            HMV_IDLE: begin
                if (st.vip) begin
                    next_st.vstate = HMV_LATENCY;
                    next_st.lat = 4'h1;
                    next_st.irq_nop = 1'b1;
                end
            end
            HMV_LATENCY: begin
                if (st.lat == 4'(VECTOR_NOP_CYC)) begin
                    next_st.vstate = HMV_SERVICE;
                    next_st.irq_enter = 1'b1;
                    next_st.status_push = 1'b1;
                end else begin
                    next_st.lat = st.lat + 4'h1;
                    next_st.irq_nop = 1'b1;
                end
            end
            HMV_SERVICE: begin
                if (core_rti) begin
                    next_st.vstate = HMV_IDLE;
                    next_st.status_pop = 1'b1;
                    next_st.vip = 1'b0;
                end
            end
        endcase
        if (!reset_n) begin
            next_st = '0;
            next_st.vector = VECTOR_RESET;
            next_st.vstate = HMV_IDLE;
        end
        next_st.in_service = (next_st.vstate == HMV_SERVICE);
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign port.ready = st.ready;
    assign port.rdata = st.rdata;
    assign core_rdata = st.core_rdata;
    assign irq_nop = st.irq_nop;
    assign irq_enter = st.irq_enter;
    assign irq_target = st.vector[VEC_ADDR_W-1:0];
    assign irq_data = st.vector[31:VEC_ADDR_W];
    assign status_push = st.status_push;
    assign status_pop = st.status_pop;
    assign in_service = st.in_service;
    assign mem_we = st.mem_we;
    assign mem_addr = st.mem_addr;
    assign mem_wdata = st.mem_wdata;
endmodule : hmv_device
`default_nettype wire

// [design/hmv_pkg.sv]
`default_nettype none
package hmv_pkg;
    // ------------------------------------------------------------
    // Register map on the shared external port (word addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] MSG_BASE_ADDR = 4'h0;
    localparam logic [3:0] VECTOR_ADDR = 4'h8;
    localparam logic [3:0] STATUS_ADDR = 4'h9;
    localparam int NUM_MSG = 8;
    localparam int VEC_ADDR_W = 24;
    localparam int STATUS_VIP_BIT = 0;
    localparam int STATUS_DWP_BIT = 1;
    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [31:0] VECTOR_RESET = 32'h0000_0040;
    localparam int VECTOR_LATENCY_CYC = 6;
    localparam int VECTOR_NOP_CYC = 5;
    localparam int DIRECT_WRITE_MAX_DELAY_CYC = 12;
    localparam int DIRECT_WRITE_DELAY_CYC = 3;
    // ------------------------------------------------------------
    // Host controller register map (AXI4-Lite byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] H_CTRL = 8'h00;
    localparam logic [7:0] H_ADDR = 8'h04;
    localparam logic [7:0] H_WDATA = 8'h08;
    localparam logic [7:0] H_RDATA = 8'h0C;
    localparam logic [7:0] H_STAT = 8'h10;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_DIRECT_BIT = 2;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    typedef enum logic [1:0] {HMV_RESP_OKAY = 2'b00, HMV_RESP_SLVERR = 2'b10} hmv_resp_t;
endpackage : hmv_pkg
`default_nettype wire

// [design/hmv_port_if.sv]
`default_nettype none
interface hmv_port_if (input wire logic clk);
    logic req;
    logic wr;
    logic direct;
    logic [3:0] addr;
    logic [31:0] wdata;
    logic ready;
    logic [31:0] rdata;
    modport dev (input req, wr, direct, addr, wdata, output ready, rdata);
    modport host (output req, wr, direct, addr, wdata, input ready, rdata);
endinterface : hmv_port_if
`default_nettype wire

// [design/hmv_host.sv]
`default_nettype none
module hmv_host
    import hmv_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    hmv_port_if.host port,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import hmv_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] aw;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [2:0] ctrl;
        logic [3:0] addr;
        logic [31:0] wdata;
        logic [31:0] result;
        logic busy;
        logic done;
        logic req;
    } hmv_host_state_t;

    hmv_host_state_t st, next_st;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                v[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return v;
    endfunction

    always_comb begin
        next_st = st;
        if (s_axi_awvalid && !st.aw_got) begin
            next_st.aw_got = 1'b1;
            next_st.aw = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_got) begin
            next_st.w_got = 1'b1;
            next_st.wd = s_axi_wdata;
            next_st.ws = s_axi_wstrb;
        end
        if (st.aw_got && st.w_got && !st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = HMV_RESP_OKAY;
            unique case (st.aw)
                H_CTRL: begin
                    next_st.ctrl = 3'(merge({29'h0, st.ctrl}, st.wd, st.ws));
                    // Bus cycle issued only when idle; extra go bits are dropped
                    if (st.ws[0] && st.wd[CTRL_GO_BIT] && !st.busy) begin
                        next_st.busy = 1'b1;
                        next_st.done = 1'b0;
                        next_st.req = 1'b1;
                    end
                end
                H_ADDR: next_st.addr = 4'(merge({28'h0, st.addr}, st.wd, st.ws));
                H_WDATA: next_st.wdata = merge(st.wdata, st.wd, st.ws);
                H_STAT: if (st.ws[0] && st.wd[STAT_DONE_BIT]) next_st.done = 1'b0;
                default: next_st.bresp = HMV_RESP_SLVERR;
            endcase
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (s_axi_arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = HMV_RESP_OKAY;
            unique case (s_axi_araddr)
                H_CTRL: next_st.rdata = {29'h0, st.ctrl};
                H_ADDR: next_st.rdata = {28'h0, st.addr};
                H_WDATA: next_st.rdata = st.wdata;
                H_RDATA: next_st.rdata = st.result;
                H_STAT: next_st.rdata = {30'h0, st.done, st.busy};
                default: begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = HMV_RESP_SLVERR;
                end
            endcase
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        // Request held until the device answers; the done bit wins over a same-cycle clear
        if (st.req && port.ready) begin
            next_st.req = 1'b0;
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
            next_st.result = port.rdata;
        end
        if (!reset_n) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign s_axi_awready = !st.aw_got;
    assign s_axi_wready = !st.w_got;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign port.req = st.req;
    assign port.wr = st.ctrl[CTRL_WRITE_BIT];
    assign port.direct = st.ctrl[CTRL_DIRECT_BIT];
    assign port.addr = st.addr;
    assign port.wdata = st.wdata;
endmodule : hmv_host
`default_nettype wire

// [bench/hmv_checker.sv]
`default_nettype none
module hmv_checker
    import hmv_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic req,
    input wire logic wr,
    input wire logic direct,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic ready,
    input wire logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic lw_ok;
        logic [3:0] lw_addr;
        logic [31:0] lw_data;
        logic vec_seen;
        logic [4:0] dw_age;
        logic [6:0] vec_age;
    } hmv_chk_t;
    localparam hmv_chk_t CHK_RESET = '{1'b0, 4'h0, 32'h0, 1'b0, 5'h1F, 7'h7F};
    hmv_chk_t st;
    hmv_chk_t next_st;
    logic rd_done;
    assign rd_done = ready && !wr;
    always_comb begin
        next_st = st;
        if (ready && wr && !direct) begin
            next_st.lw_ok = 1'b1;
            next_st.lw_addr = addr;
            next_st.lw_data = wdata;
        end else if (rd_done) begin
            next_st.lw_ok = 1'b0;
        end
        if (ready && !direct && addr == VECTOR_ADDR) next_st.vec_seen = 1'b1;
        if (ready && wr && direct) next_st.dw_age = 5'h0;
        else if (st.dw_age != 5'h1F) next_st.dw_age = st.dw_age + 5'h1;
        if (ready && wr && !direct && addr == VECTOR_ADDR) next_st.vec_age = 7'h0;
        else if (st.vec_age != 7'h7F) next_st.vec_age = st.vec_age + 7'h1;
        if (!reset_n) next_st = CHK_RESET;
    end
    always_ff @(posedge clk) begin
        st <= next_st;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ------------------------------------------------------------
    // Port handshake
    // ------------------------------------------------------------
    property p_ready_pulse; $rose(ready) |=> $fell(ready); endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held past one cycle");
    property p_ready_has_req; ready |-> req; endproperty
    a_ready_has_req: assert property (p_ready_has_req) else $error("ready without a request");
    // Register accesses never queue behind a direct write
    property p_reg_answer; req && !ready && !direct |=> ready; endproperty
    a_reg_answer: assert property (p_reg_answer) else $error("register access not answered next cycle");
    property p_direct_bound; req && direct && !ready |-> ##[1:14] ready; endproperty
    a_direct_bound: assert property (p_direct_bound) else $error("direct write held off too long");
    // ------------------------------------------------------------
    // Register contents and flags
    // ------------------------------------------------------------
    property p_readback;
        rd_done && st.lw_ok && addr == st.lw_addr && addr < VECTOR_ADDR |-> rdata == st.lw_data;
    endproperty
    a_readback: assert property (p_readback) else $error("message read differs from last write");
    property p_vec_reset; rd_done && addr == VECTOR_ADDR && !st.vec_seen |-> rdata == VECTOR_RESET; endproperty
    a_vec_reset: assert property (p_vec_reset) else $error("vector register lost its reset value");
    property p_dwp_clear; rd_done && addr == STATUS_ADDR && st.dw_age > 5'd13 |-> !rdata[STATUS_DWP_BIT]; endproperty
    a_dwp_clear: assert property (p_dwp_clear) else $error("direct write flag stuck");
    // Bench keeps the return well away from the vector write
    property p_vip_set; rd_done && addr == STATUS_ADDR && st.vec_age < 7'd48 |-> rdata[STATUS_VIP_BIT]; endproperty
    a_vip_set: assert property (p_vip_set) else $error("vector pending flag not set");
endmodule // hmv_checker
`default_nettype wire

// [bench/tb_host_mailbox_vector_irq.sv]
`default_nettype none
module tb_host_mailbox_vector_irq;
    timeunit 1ns;
    timeprecision 1ns;
    import hmv_pkg::*;
    typedef struct packed {logic [3:0] a; logic [31:0] d;} hmv_row_t;
    hmv_row_t rows [8] = '{'{4'h0, 32'h1}, '{4'h1, 32'h8000_0000}, '{4'h2, 32'hFFFF_FFFF}, '{4'h3, 32'h5A5A_5A5A},
        '{4'h4, 32'hA5A5_A5A5}, '{4'h5, 32'h1234_5678}, '{4'h6, 32'h0000_FFFF}, '{4'h7, 32'hFFFF_0000}};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata_s = 32'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, last_resp;
    logic [31:0] rdata_s, core_rdata, mem_wdata, r, last_mdata, exp_vec;
    logic core_wr = 1'b0, core_rti = 1'b0;
    logic [3:0] core_addr = 4'h0, mem_addr, last_maddr;
    logic [31:0] core_wdata = 32'h0;
    logic irq_nop, irq_enter, status_push, status_pop, in_service, mem_we;
    logic [23:0] irq_target;
    logic [7:0] irq_data;
    int mismatches = 0, checks_done = 0, cyc = 0, nop_run = 0, enters = 0, pops = 0, mems = 0, dw_age = 0;
    always #50 clk = ~clk;
    hmv_port_if hmv_port_if_i (.clk(clk));
    hmv_device #(.DW_DELAY(DIRECT_WRITE_DELAY_CYC)) hmv_device_i (.clk(clk), .reset_n(reset_n), .port(hmv_port_if_i),
        .core_wr(core_wr), .core_addr(core_addr), .core_wdata(core_wdata), .core_rti(core_rti),
        .core_rdata(core_rdata), .irq_nop(irq_nop), .irq_enter(irq_enter), .irq_target(irq_target),
        .irq_data(irq_data), .status_push(status_push), .status_pop(status_pop), .in_service(in_service),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
    hmv_host hmv_host_i (.clk(clk), .reset_n(reset_n), .port(hmv_port_if_i), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata_s), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata_s), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    hmv_checker hmv_checker_i (.clk(clk), .reset_n(reset_n), .req(hmv_port_if_i.req), .wr(hmv_port_if_i.wr),
        .direct(hmv_port_if_i.direct), .addr(hmv_port_if_i.addr), .wdata(hmv_port_if_i.wdata),
        .ready(hmv_port_if_i.ready), .rdata(hmv_port_if_i.rdata));
    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        dw_age++;
        if (mem_we === 1'b1) chk(32'(dw_age), 32'(DIRECT_WRITE_DELAY_CYC));
        if (hmv_port_if_i.ready === 1'b1 && hmv_port_if_i.direct === 1'b1) dw_age = 0;
        if (irq_enter === 1'b1) begin
            chk(32'(nop_run), VECTOR_NOP_CYC);
            chk({31'h0, status_push}, 32'h1);
            chk({irq_data, irq_target}, exp_vec);
            enters++;
        end
        nop_run = (irq_nop === 1'b1) ? nop_run + 1 : 0;
        if (status_pop === 1'b1) pops++;
        if (mem_we === 1'b1) begin
            mems++;
            last_maddr = mem_addr;
            last_mdata = mem_wdata;
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            final_report();
        end
    end
    // ------------------------------------------------------------
    // Bus and core drivers
    // ------------------------------------------------------------
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata_s <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                last_resp = bresp;
                done = 1'b1;
            end
        end
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                d = rdata_s;
                last_resp = rresp;
                done = 1'b1;
            end
        end
    endtask
    task automatic port_op(input logic w, input logic dir, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        logic [31:0] s;
        axi_wr(H_ADDR, {28'h0, a});
        axi_wr(H_WDATA, d);
        axi_wr(H_CTRL, {29'h0, dir, w, 1'b1});
        s = 32'h0;
        while (s[STAT_DONE_BIT] !== 1'b1) axi_rd(H_STAT, s);
        axi_wr(H_STAT, 32'h2);
        axi_rd(H_RDATA, q);
    endtask
    task automatic core_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        core_wr <= 1'b1;
        core_addr <= a;
        core_wdata <= d;
        @(posedge clk);
        core_wr <= 1'b0;
    endtask
    task automatic core_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        core_addr <= a;
        repeat (2) @(posedge clk);
        d = core_rdata;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        foreach (rows[i]) port_op(1'b1, 1'b0, rows[i].a, rows[i].d, r);
        foreach (rows[i]) begin
            port_op(1'b0, 1'b0, rows[i].a, 32'h0, r);
            chk(r, rows[i].d);
            core_read(rows[i].a, r);
            chk(r, rows[i].d);
        end
        port_op(1'b0, 1'b0, VECTOR_ADDR, 32'h0, r);
        chk(r, VECTOR_RESET);
        port_op(1'b0, 1'b0, STATUS_ADDR, 32'h0, r);
        chk(r, 32'h0);
        axi_rd(8'h3C, r);
        chk({30'h0, last_resp}, {30'h0, HMV_RESP_SLVERR});
        chk(r, 32'h0);
        core_write(VECTOR_ADDR, 32'h0);
        repeat (8) @(posedge clk);
        chk(32'(enters), 32'h0);
        port_op(1'b0, 1'b0, VECTOR_ADDR, 32'h0, r);
        chk(r, 32'h0);
        port_op(1'b1, 1'b1, 4'h6, 32'hCAFE_0001, r);
        r = 32'h2;
        while (r[STATUS_DWP_BIT] !== 1'b0) port_op(1'b0, 1'b0, STATUS_ADDR, 32'h0, r);
        chk(32'(mems), 32'h1);
        chk({last_maddr, last_mdata[27:0]}, 32'h6AFE_0001);
        exp_vec = 32'hA500_1234;
        port_op(1'b1, 1'b0, VECTOR_ADDR, exp_vec, r);
        port_op(1'b0, 1'b0, STATUS_ADDR, 32'h0, r);
        chk({31'h0, r[STATUS_VIP_BIT]}, 32'h1);
        chk({31'h0, in_service}, 32'h1);
        port_op(1'b1, 1'b0, VECTOR_ADDR, 32'h1100_0777, r);
        port_op(1'b0, 1'b0, VECTOR_ADDR, 32'h0, r);
        chk(r, exp_vec);
        core_read(4'h0, r);
        chk(r, rows[0].d);
        port_op(1'b1, 1'b0, 4'h2, 32'h0BAD_F00D, r);
        port_op(1'b1, 1'b0, 4'h3, 32'h1, r);
        core_read(4'h2, r);
        chk(r, 32'h0BAD_F00D);
        core_write(4'h3, 32'h0);
        port_op(1'b0, 1'b0, STATUS_ADDR, 32'h0, r);
        port_op(1'b0, 1'b0, 4'h3, 32'h0, r);
        chk(r, 32'h0);
        chk(32'(enters), 32'h1);
        core_write(VECTOR_ADDR, 32'h0);
        core_rti <= 1'b1;
        @(posedge clk);
        core_rti <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'(pops), 32'h1);
        port_op(1'b0, 1'b0, STATUS_ADDR, 32'h0, r);
        chk(r, 32'h0);
        port_op(1'b0, 1'b0, VECTOR_ADDR, 32'h0, r);
        chk(r, 32'h0);
        core_write(4'h4, 32'h77);
        port_op(1'b0, 1'b0, 4'h4, 32'h0, r);
        chk(r, 32'h77);
        port_op(1'b1, 1'b0, 4'h4, 32'h0, r);
        core_read(4'h4, r);
        chk(r, 32'h0);
        port_op(1'b0, 1'b0, 4'h4, 32'h0, r);
        chk(r, 32'h0);
        // ------------------------------------------------------------
        // Reset in mid-run
        // ------------------------------------------------------------
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        port_op(1'b0, 1'b0, VECTOR_ADDR, 32'h0, r);
        chk(r, VECTOR_RESET);
        port_op(1'b0, 1'b0, STATUS_ADDR, 32'h0, r);
        chk(r, 32'h0);
        final_report();
    end
endmodule // tb_host_mailbox_vector_irq
`default_nettype wire
